// file: design/crs_regs.svh
/*
 Constants for the charger serial slave port: address, codes, register map.
 Assumes inclusion by the slave design file only.
*/
`ifndef CRS_REGS_SVH
`define CRS_REGS_SVH
`define CRS_SLAVE_ADDR 7'h6b
`define CRS_HS_CODE_HI 5'h01
`define CRS_NUM_REGS 5
`define CRS_RO_INDEX 3
`define CRS_UNMAPPED_DATA 8'hff
`define CRS_BIT_PRESTART 4'hf
`define CRS_RST_R0 8'h40
`define CRS_RST_R1 8'h30
`define CRS_RST_R2 8'h0a
`define CRS_RST_R3 8'h40
`define CRS_RST_R4 8'h00
`endif

// file: design/crs_pkg.sv
/*
 Types for the charger serial slave port.
 Includes no header and does not need crs_regs.svh on the include path.
*/
package crs_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_REGA,
    ST_DATA,
    ST_READ,
    ST_IGNORE
  } crs_state_e;
  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic sda;
  } crs_bus_ev_s;
endpackage

// file: design/crs_bus_sync.sv
/*
 Two-stage synchroniser and start/stop/edge detector for the bus pins.
 Assumes pins are asynchronous to CLK and much slower than it.
*/
`timescale 1ns/1ps
module crs_bus_sync
  import crs_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  output crs_bus_ev_s ev
);
  // ==========================================
  // Synchroniser
  logic [1:0] scl_meta_reg;
  logic [1:0] sda_meta_reg;
  logic scl_q_reg;
  logic sda_q_reg;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_meta_reg <= 2'h3;
      sda_meta_reg <= 2'h3;
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else begin
      scl_meta_reg <= {scl_meta_reg[0], scl_in};
      sda_meta_reg <= {sda_meta_reg[0], sda_in};
      scl_q_reg <= scl_meta_reg[1];
      sda_q_reg <= sda_meta_reg[1];
    end
  end
  // ==========================================
  // Events
  always_comb begin
    ev.start = scl_meta_reg[1] && scl_q_reg && sda_q_reg && !sda_meta_reg[1];
    ev.stop = scl_meta_reg[1] && scl_q_reg && !sda_q_reg && sda_meta_reg[1];
    ev.rise = scl_meta_reg[1] && !scl_q_reg;
    ev.fall = !scl_meta_reg[1] && scl_q_reg;
    ev.sda = sda_meta_reg[1];
  end
endmodule

// file: design/crs_slave.sv
/*
 Serial slave port of a charger: register writes, reads, high-speed entry.
 Assumes a bus master on SCL/SDA; SDA open-drain resolved outside.
*/
`timescale 1ns/1ps
`include "crs_regs.svh"
module crs_slave
  import crs_pkg::*;
#(
  parameter int NUM_REGS = `CRS_NUM_REGS
)(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  output logic HS_MODE,
  output logic [8*NUM_REGS-1:0] REG_FLAT
);
  // ==========================================
  // Pin sampling
  crs_bus_ev_s ev;
  crs_bus_sync u_sync (
    .clk(CLK),
    .nrst(NRST),
    .scl_in(SCL_IN),
    .sda_in(SDA_IN),
    .ev(ev)
  );

  function automatic logic [7:0] reset_val(input int idx);
    case (idx)
      0: reset_val = `CRS_RST_R0;
      1: reset_val = `CRS_RST_R1;
      2: reset_val = `CRS_RST_R2;
      3: reset_val = `CRS_RST_R3;
      default: reset_val = `CRS_RST_R4;
    endcase
  endfunction

  // ==========================================
  // Bit counter and shifter
  crs_state_e state_reg;
  logic [3:0] bit_reg;
  logic [7:0] shift_reg;
  logic [7:0] rega_reg;
  logic [7:0] tx_reg;
  logic ack_reg;
  logic commit_reg;
  logic ack_done;
  logic byte_done;
  logic [7:0] mem_reg [NUM_REGS];
  logic hs_reg;
  logic addr_hit;
  logic is_code;
  logic [7:0] rd_val;

  assign byte_done = ev.fall && bit_reg == 4'h7;
  assign ack_done = ev.fall && bit_reg == 4'h8;
  assign addr_hit = shift_reg[7:1] == `CRS_SLAVE_ADDR;
  assign is_code = shift_reg[7:3] == `CRS_HS_CODE_HI;
  assign rd_val = (rega_reg < 8'(NUM_REGS)) ? mem_reg[rega_reg[2:0]] : `CRS_UNMAPPED_DATA;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
    end else if (ev.start) begin
      bit_reg <= `CRS_BIT_PRESTART; // Fall after start wraps to bit 0
    end else if (ev.stop) begin
      bit_reg <= 4'h0;
    end else if (ev.rise && bit_reg < 4'h8) begin
      shift_reg <= {shift_reg[6:0], ev.sda};
    end else if (ev.fall) begin
      bit_reg <= (bit_reg == 4'h8) ? 4'h0 : bit_reg + 4'h1;
    end
  end

  // ==========================================
  // Transfer state
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_reg <= ST_IDLE;
      ack_reg <= 1'b0;
      commit_reg <= 1'b0;
      rega_reg <= 8'h00;
    end else if (ev.stop) begin
      state_reg <= ST_IDLE;
      ack_reg <= 1'b0;
      commit_reg <= 1'b0;
    end else if (ev.start) begin
      state_reg <= ST_ADDR;
      ack_reg <= 1'b0;
      commit_reg <= 1'b0;
    end else if (byte_done) begin
      ack_reg <= 1'b0;
      commit_reg <= 1'b0;
      case (state_reg)
        ST_ADDR: begin
          if (addr_hit) begin
            ack_reg <= 1'b1;
            state_reg <= shift_reg[0] ? ST_READ : ST_REGA;
          end else begin
            state_reg <= ST_IGNORE;
          end
        end
        ST_REGA: begin
          rega_reg <= shift_reg;
          ack_reg <= 1'b1;
          state_reg <= ST_DATA;
        end
        ST_DATA: begin
          ack_reg <= 1'b1;
          commit_reg <= 1'b1;
          state_reg <= ST_REGA;
        end
        ST_READ: state_reg <= ST_READ;
        ST_IDLE: state_reg <= ST_IDLE;
        ST_IGNORE: state_reg <= ST_IGNORE;
        default: state_reg <= ST_IDLE;
      endcase
    end else if (ack_done) begin
      ack_reg <= 1'b0;
      commit_reg <= 1'b0;
      if (state_reg == ST_READ && ev.sda) begin
        state_reg <= ST_IGNORE;
      end
    end
  end

  // ==========================================
  // High-speed flag
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      hs_reg <= 1'b0;
    end else if (ev.stop) begin
      hs_reg <= 1'b0;
    end else if (byte_done && state_reg == ST_ADDR && is_code) begin
      hs_reg <= 1'b1;
    end
  end

  // ==========================================
  // Register file
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_mem
      always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
          mem_reg[gi] <= reset_val(gi);
        end else if (ack_done && commit_reg &&
                     rega_reg == 8'(gi) && gi != `CRS_RO_INDEX) begin
          mem_reg[gi] <= shift_reg;
        end
      end
      assign REG_FLAT[8*gi +: 8] = mem_reg[gi];
    end
  endgenerate

  // ==========================================
  // Read data and pin drive
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      tx_reg <= 8'hff;
    end else if (byte_done && state_reg == ST_ADDR) begin
      tx_reg <= rd_val;
    end else if (ack_done && state_reg == ST_READ) begin
      tx_reg <= rd_val;
    end else if (ev.fall && state_reg == ST_READ && bit_reg < 4'h7) begin
      tx_reg <= {tx_reg[6:0], 1'b1};
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      SDA_OE <= 1'b0;
      HS_MODE <= 1'b0;
    end else begin
      HS_MODE <= hs_reg;
      SDA_OE <= ack_reg || (state_reg == ST_READ && bit_reg < 4'h8 && !tx_reg[7]);
    end
  end
  assign SDA_OUT = 1'b0;

  // ==========================================
  // Checks
  a_stop_idle: assert property (@(posedge CLK) disable iff (!NRST)
    ev.stop |=> state_reg == ST_IDLE && !hs_reg) else $error("stop not idle");
  a_hs_noack: assert property (@(posedge CLK) disable iff (!NRST)
    byte_done && state_reg == ST_ADDR && is_code |=> !ack_reg) else $error("code acked");
  a_hs_clear: assert property (@(posedge CLK) disable iff (!NRST)
    hs_reg && ev.stop |=> ##1 !HS_MODE) else $error("hs kept");
  a_ack_drive: assert property (@(posedge CLK) disable iff (!NRST)
    ack_reg |=> SDA_OE) else $error("ack not driven");
  a_ro_keep: assert property (@(posedge CLK) disable iff (!NRST)
    $stable(mem_reg[`CRS_RO_INDEX])) else $error("ro written");
  a_miss_quiet: assert property (@(posedge CLK) disable iff (!NRST)
    state_reg == ST_IGNORE |=> !ack_reg) else $error("ack on miss");
  a_release_stop: assert property (@(posedge CLK) disable iff (!NRST)
    ev.stop |=> ##1 !SDA_OE) else $error("sda held");
  a_first_addr: assert property (@(posedge CLK) disable iff (!NRST)
    ev.start |=> state_reg == ST_ADDR && bit_reg == `CRS_BIT_PRESTART) else $error("no addr");
  sequence s_addr_match;
    byte_done && state_reg == ST_ADDR && addr_hit;
  endsequence
  sequence s_write_commit;
    ack_done && commit_reg && rega_reg == 8'h01;
  endsequence
  a_addr_ack: assert property (@(posedge CLK) disable iff (!NRST)
    s_addr_match |=> ack_reg ##1 SDA_OE) else $error("address not acked");
  a_commit_write: assert property (@(posedge CLK) disable iff (!NRST)
    s_write_commit |=> mem_reg[1] == $past(shift_reg)) else $error("write not committed");
endmodule

// file: tb/crs_master_model.sv
/*
 Bus master model for the charger serial slave port.
 Assumes CLK at 25 MHz; SCL low 5 CLK, high 3 CLK (320 ns per bit); SDA open drain.
*/
`timescale 1ns/1ps
module crs_master_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_oe
);
  // ==========
  // Bus tasks
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  task automatic q(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Data moves only while SCL low
  task automatic bitx(input logic b, output logic r);
    q(1);
    sda_oe <= ~b;
    q(4);
    scl <= 1'b1;
    q(2);
    r = sda;
    q(1);
    scl <= 1'b0;
  endtask
  // Start or repeated start
  task automatic start();
    q(1);
    sda_oe <= 1'b0;
    q(7);
    scl <= 1'b1;
    q(3);
    sda_oe <= 1'b1;
    q(3);
    scl <= 1'b0;
  endtask
  // Stop ends transfers and aborts
  task automatic stop();
    q(1);
    sda_oe <= 1'b1;
    q(7);
    scl <= 1'b1;
    q(3);
    sda_oe <= 1'b0;
    q(3);
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(b[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(nack, r);
  endtask
endmodule

// file: tb/crs_slave_tb_top.sv
/*
 Self-checking bench for the charger serial slave port.
 Assumes the master model drives SCL and pulls SDA low.
*/
`timescale 1ns/1ps
module crs_slave_tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic scl, m_oe, s_oe, s_out, hs;
  logic [39:0] regs, exp_regs;
  wire sda = ~m_oe & (s_oe ? s_out : 1'b1);
  int n_errors = 0;
  int n_checks = 0;
  always #20 clk = ~clk;
  crs_master_model M (.clk(clk), .sda(sda), .scl(scl), .sda_oe(m_oe));
  crs_slave DUT (.CLK(clk), .NRST(nrst), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(s_out),
    .SDA_OE(s_oe), .HS_MODE(hs), .REG_FLAT(regs));
  // ==========
  // Helpers
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] b, input logic ea);
    logic a;
    M.wbyte(b, a);
    chk(40'(a), 40'(ea));
  endtask
  task automatic rd(input logic [7:0] ra, input logic [7:0] ed);
    logic [7:0] d;
    M.start();
    wr(8'hd6, 1'b1);
    wr(ra, 1'b1);
    M.start();
    wr(8'hd7, 1'b1);
    M.rbyte(1'b1, d);
    M.stop();
    chk(40'(d), 40'(ed));
  endtask
  // ==========
  // Scenarios
  task automatic t_reset();
    chk(regs, 40'h00400a3040);
    chk({37'h0, s_out, hs, s_oe}, 40'h0);
    $display("reset test done");
  endtask
  task automatic t_write();
    M.start();
    wr(8'hd6, 1'b1);
    wr(8'h01, 1'b1);
    wr(8'h5a, 1'b1);
    chk(40'(regs[15:8]), 40'h30);
    M.q(8);
    chk(40'(regs[15:8]), 40'h5a);
    wr(8'h02, 1'b1);
    wr(8'hc3, 1'b1);
    wr(8'h03, 1'b1);
    wr(8'h11, 1'b1);
    M.stop();
    exp_regs = 40'h0040c35a40;
    chk(regs, exp_regs);
    chk(40'(s_oe), 40'h0);
    rd(8'h01, 8'h5a);
    rd(8'h03, 8'h40);
    rd(8'h09, 8'hff);
    $display("write and read test done");
  endtask
  task automatic t_nomatch();
    M.start();
    wr(8'hd4, 1'b0);
    wr(8'h01, 1'b0);
    wr(8'h77, 1'b0);
    M.start();
    wr(8'hf0, 1'b0);
    wr(8'hd6, 1'b0);
    M.stop();
    chk(regs, exp_regs);
    $display("mismatch test done");
  endtask
  task automatic t_hs();
    M.start();
    wr(8'h09, 1'b0);
    chk(40'(hs), 40'h1);
    M.start();
    wr(8'hd6, 1'b1);
    wr(8'h00, 1'b1);
    wr(8'h2c, 1'b1);
    chk(40'(hs), 40'h1);
    M.stop();
    M.q(6);
    chk(40'(hs), 40'h0);
    exp_regs[7:0] = 8'h2c;
    chk(regs, exp_regs);
    $display("high-speed test done");
  endtask
  task automatic t_abort();
    logic r;
    M.start();
    wr(8'hd6, 1'b1);
    wr(8'h01, 1'b1);
    repeat (3) M.bitx(1'b0, r);
    M.stop();
    M.q(2);
    chk(40'(s_oe), 40'h0);
    chk(regs, exp_regs);
    M.start();
    wr(8'hd6, 1'b1);
    wr(8'h01, 1'b1);
    wr(8'h99, 1'b1);
    M.stop();
    exp_regs[15:8] = 8'h99;
    chk(regs, exp_regs);
    $display("abort test done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    exp_regs = 40'h00400a3040;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    M.q(4);
    t_reset();
    t_write();
    t_nomatch();
    t_hs();
    t_abort();
    tally_and_finish();
  end
  initial begin
    #2000000;
    n_errors++;
    tally_and_finish();
  end
endmodule
